// ### hdl/lcf_frame_tx.sv
// Serialiser that turns one device request into a frame of 16-bit link words.
`timescale 1ns/1ns
`default_nettype none
module lcf_frame_tx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire lcf_pkg::lcf_req_s req,
  input wire logic tx_ready,
  output logic tx_valid,
  output lcf_pkg::lcf_word_s tx,
  output logic sent
);
  import lcf_pkg::*;

  logic active;
  logic [2:0] step;
  lcf_req_s held;
  logic [2:0] last_step;
  logic accept;

  // Frame word at a given step: function, address, then count or value, then data high and low.
  function automatic logic [15:0] word_at(input logic [2:0] s, input lcf_req_s r);
    logic [15:0] w;
    w = 16'h0000;
    unique case (s)
      3'h0: w = {8'h00, r.func};
      3'h1: w = r.addr;
      3'h2: w = (r.func == FC_WRITE_ONE) ? r.data[15:0] : {14'h0000, r.count};
      3'h3: w = r.data[31:16];
      default: w = r.data[15:0];
    endcase
    return w;
  endfunction

  function automatic logic [2:0] last_of(input lcf_req_s r);
    return (r.func == FC_WRITE_MULTI) ? 3'h4 : 3'h2;
  endfunction

  assign last_step = last_of(held);
  assign tx_valid = active;
  assign accept = active && tx_ready;
  assign sent = accept && tx.last;

  // Words advance only on acceptance, so a stalled link holds the current word.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      step <= 3'h0;
      held <= '0;
      tx <= '0;
    end else if (start && !active) begin
      active <= 1'b1;
      step <= 3'h0;
      held <= req;
      tx <= '{word: word_at(3'h0, req), last: 1'b0};
    end else if (accept) begin
      if (step == last_step) begin
        active <= 1'b0;
        tx <= '0;
      end else begin
        step <= step + 3'h1;
        tx <= '{word: word_at(step + 3'h1, held), last: (step + 3'h1) == last_step};
      end
    end
  end

  // A float write carries the high half before the low half.
  hi_half_first_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (accept && held.func == FC_WRITE_MULTI && step == 3'h3)
      |-> tx.word == held.data[31:16] ##1 (tx.word == held.data[15:0] && tx.last))
    else $error("float halves leave in the wrong order");

  // A multi-register write announces a count of two.
  multi_count_two_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (accept && held.func == FC_WRITE_MULTI && step == 3'h2) |-> tx.word == 16'h0002)
    else $error("multi-register write count is not two");

  held_word_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx)))
    else $error("link word changed while stalled");

endmodule
`default_nettype wire

// ### hdl/lcf_host_ctrl.sv
// Host controller that programs the electronic load's parameters over its register link.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module lcf_host_ctrl #(
  parameter int unsigned TIMEOUT_CYCLES = lcf_pkg::RESP_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [lcf_pkg::SW_ADDR_W-1:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  output lcf_pkg::lcf_word_s link_tx,
  input wire logic link_rx_valid,
  input wire lcf_pkg::lcf_word_s link_rx
);
  import lcf_pkg::*;

  logic [1:0] rst_sync;
  logic rst_i_n;
  lcf_state_e state;
  logic [31:0] wdata;
  logic [31:0] read_value;
  logic [31:0] acc;
  logic [31:0] wait_cnt;
  logic [IDX_W-1:0] cmd_idx;
  logic cmd_read;
  logic cmd_float;
  logic st_done;
  logic st_timeout;
  logic st_refused;
  logic [3:0] origin_shadow;
  logic [3:0] wave_shadow;
  logic cmd_wr;
  logic [IDX_W-1:0] new_idx;
  logic [IDX_W-1:0] safe_idx;
  logic new_read;
  logic new_float;
  logic idx_ok;
  logic value_ok;
  logic refuse;
  logic start;
  logic sent;
  logic answer_end;
  logic timed_out;
  lcf_req_s req;

  // Reset is released through two flops so that every flop leaves reset on the same edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_i_n = rst_sync[1];

  // Decode of a command write and its legality against the parameter table.
  assign cmd_wr = sw_wr && (sw_addr == REG_CMD);
  assign new_idx = sw_wdata[IDX_W-1:0];
  assign new_read = sw_wdata[CMD_READ_BIT];
  assign idx_ok = (new_idx <= IDX_LAST);
  assign safe_idx = idx_ok ? new_idx : '0;
  assign new_float = PARAM_FLOAT[safe_idx];
  // Integer values outside the documented encodings are never sent.
  assign value_ok = (wdata[15:0] >= {12'h000, PARAM_MIN[safe_idx]}) &&
                    (wdata[15:0] <= {12'h000, PARAM_MAX[safe_idx]});
  // The restore entry has no query address, so reading it is refused.
  assign refuse = !idx_ok || (new_read && !PARAM_READABLE[safe_idx]) ||
                  (!new_read && !new_float && !value_ok);
  assign start = cmd_wr && (state == LCF_IDLE) && !refuse;
  assign answer_end = (state == LCF_WAIT) && link_rx_valid && link_rx.last;
  assign timed_out = (state == LCF_WAIT) && !answer_end &&
                     (wait_cnt == 32'(TIMEOUT_CYCLES - 1));

  // Request built from the table: code, address, count and data per parameter kind.
  always_comb begin
    req = '0;
    req.count = new_float ? FLOAT_REG_COUNT : INT_REG_COUNT;
    if (new_read) begin
      req.func = FC_READ;
      req.addr = PARAM_RD_ADDR[safe_idx];
    end else begin
      req.func = new_float ? FC_WRITE_MULTI : FC_WRITE_ONE;
      req.addr = PARAM_WR_ADDR[safe_idx];
      req.data = new_float ? wdata : {16'h0000, wdata[15:0]};
    end
  end

  lcf_frame_tx u_frame_tx (
    .clk(clk),
    .rst_n(rst_i_n),
    .start(start),
    .req(req),
    .tx_ready(link_tx_ready),
    .tx_valid(link_tx_valid),
    .tx(link_tx),
    .sent(sent)
  );

  // Transfer sequence: frame out, then wait for the answer or give up.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      state <= LCF_IDLE;
    end else begin
      unique case (state)
        LCF_IDLE: begin
          if (start) begin
            state <= LCF_SEND;
          end
        end
        LCF_SEND: begin
          if (sent) begin
            state <= LCF_WAIT;
          end
        end
        LCF_WAIT: begin
          if (answer_end || timed_out) begin
            state <= LCF_IDLE;
          end
        end
        default: begin
          state <= LCF_IDLE;
        end
      endcase
    end
  end

  // Command capture for the transfer in flight.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      cmd_idx <= '0;
      cmd_read <= 1'b0;
      cmd_float <= 1'b0;
    end else if (start) begin
      cmd_idx <= new_idx;
      cmd_read <= new_read;
      cmd_float <= new_float;
    end
  end

  // Answer timeout counter, running only while waiting.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      wait_cnt <= 32'h0000_0000;
    end else if (state == LCF_WAIT) begin
      wait_cnt <= wait_cnt + 32'h0000_0001;
    end else begin
      wait_cnt <= 32'h0000_0000;
    end
  end

  // Answer words shift in high first, so a float read lands as one 32-bit value.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      acc <= 32'h0000_0000;
      read_value <= 32'h0000_0000;
    end else if (start) begin
      acc <= 32'h0000_0000;
    end else if ((state == LCF_WAIT) && link_rx_valid) begin
      acc <= {acc[15:0], link_rx.word};
      if (link_rx.last && cmd_read) begin
        read_value <= {acc[15:0], link_rx.word};
      end
    end
  end

  // Write-data register that software fills before issuing a write command.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      wdata <= WDATA_RESET;
    end else if (sw_wr && (sw_addr == REG_WDATA)) begin
      wdata <= sw_wdata;
    end
  end

  // Sticky status; a new accepted command clears it and cannot meet a set in the same cycle.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      st_done <= 1'b0;
      st_timeout <= 1'b0;
      st_refused <= 1'b0;
    end else if (start) begin
      st_done <= 1'b0;
      st_timeout <= 1'b0;
      st_refused <= 1'b0;
    end else begin
      if (answer_end) begin
        st_done <= 1'b1;
      end
      if (timed_out) begin
        st_timeout <= 1'b1;
      end
      if (cmd_wr && ((state != LCF_IDLE) || refuse)) begin
        st_refused <= 1'b1;
      end
    end
  end

  // Host-side copy of origin and waveform, learned from completed writes and reads.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      origin_shadow <= ORIGIN_LOCAL;
      wave_shadow <= WAVE_SINE;
    end else if (answer_end) begin
      if (cmd_idx == IDX_ORIGIN) begin
        origin_shadow <= cmd_read ? link_rx.word[3:0] : wdata[3:0];
      end
      if (cmd_idx == IDX_WAVEFORM) begin
        wave_shadow <= cmd_read ? link_rx.word[3:0] : wdata[3:0];
      end
    end
  end

  // Read port: data stand in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sw_rdata <= 32'h0000_0000;
    end else if (sw_rd) begin
      unique case (sw_addr)
        REG_CMD: sw_rdata <= {23'h000000, cmd_read, 3'h0, cmd_idx};
        REG_WDATA: sw_rdata <= wdata;
        // Parameters only drive the load while the generator is the origin.
        REG_STATUS: sw_rdata <= {27'h0000000, origin_shadow == ORIGIN_FUNCGEN,
                                 st_refused, st_timeout, st_done, state != LCF_IDLE};
        REG_RDATA: sw_rdata <= read_value;
        REG_SHADOW: sw_rdata <= {24'h000000, wave_shadow, origin_shadow};
        default: sw_rdata <= 32'h0000_0000;
      endcase
    end else begin
      sw_rdata <= 32'h0000_0000;
    end
  end

  // Two answer words in a row, high then last.
  sequence float_pair_s;
    ((state == LCF_WAIT) && cmd_read && cmd_float && link_rx_valid && !link_rx.last)
      ##1 (link_rx_valid && link_rx.last);
  endsequence

  float_pair_join_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    float_pair_s |=> read_value == {$past(link_rx.word, 2), $past(link_rx.word)})
    else $error("float read not joined high word first");

  read_code_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (start && new_read) |=> (link_tx_valid && link_tx.word == {8'h00, FC_READ}))
    else $error("read frame does not open with the read code");

  float_write_code_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (start && !new_read && new_float)
      |=> (link_tx.word == {8'h00, FC_WRITE_MULTI}) && (state == LCF_SEND))
    else $error("float write does not use the multi-register code");

  int_write_code_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (start && !new_read && !new_float) |=> link_tx.word == {8'h00, FC_WRITE_ONE})
    else $error("integer write does not use the single-register code");

  mode_range_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (start && !new_read && new_idx == IDX_MODE)
      |-> (wdata[15:0] >= 16'h0001 && wdata[15:0] <= 16'h0006))
    else $error("illegal regulation mode sent");

  restore_no_read_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (cmd_wr && state == LCF_IDLE && new_read && new_idx == IDX_RESTORE)
      |=> (state == LCF_IDLE) && st_refused)
    else $error("read of the restore register was sent");

  origin_learn_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (answer_end && !cmd_read && cmd_idx == IDX_ORIGIN) |=> origin_shadow == $past(wdata[3:0]))
    else $error("origin copy not updated after write");

  wait_bounded_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (state == LCF_WAIT) |-> wait_cnt < 32'(TIMEOUT_CYCLES))
    else $error("answer wait exceeded the timeout");

  // Values that leave toward the device stay inside their documented encodings.
  wave_range_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (start && !new_read && new_idx == IDX_WAVEFORM)
      |-> wdata[15:0] <= {12'h000, WAVE_RAMP})
    else $error("illegal waveform select sent");

  origin_range_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (start && !new_read && new_idx == IDX_ORIGIN)
      |-> wdata[15:0] <= {12'h000, ORIGIN_ANALOG})
    else $error("illegal set-point origin sent");

  restore_value_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (start && new_idx == IDX_RESTORE)
      |-> !new_read && (wdata[15:0] == {12'h000, RESTORE_SOFT} ||
                        wdata[15:0] == {12'h000, RESTORE_HARD}))
    else $error("illegal restore request sent");

  // An integer answer fills only the low half, so a stale float half never leaks.
  int_read_zero_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (answer_end && cmd_read && !cmd_float) |=> read_value[31:16] == 16'h0000)
    else $error("integer read left a stale high half");

  refuse_no_frame_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    (cmd_wr && (state == LCF_IDLE) && refuse) |=> (state == LCF_IDLE) && !link_tx_valid)
    else $error("refused command still sent a frame");

  done_goes_idle_a: assert property (
    @(posedge clk) disable iff (!rst_i_n)
    answer_end |=> (state == LCF_IDLE) && st_done && !st_timeout)
    else $error("answer did not close the transfer");

endmodule
`default_nettype wire

// ### hdl/lcf_pkg.sv
// Shared constants, device register map and carrier types for the load controller host.
package lcf_pkg;

  // Clock and answer timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESP_TIMEOUT_US = 1000;
  localparam int unsigned RESP_TIMEOUT_CYCLES = RESP_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  // Function codes spoken on the device link.
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [1:0] FLOAT_REG_COUNT = 2'h2;
  localparam logic [1:0] INT_REG_COUNT = 2'h1;

  // Parameter table indexes that the controller treats specially.
  localparam int unsigned NUM_PARAMS = 21;
  localparam int unsigned IDX_W = 5;
  localparam logic [IDX_W-1:0] IDX_LAST = 5'h14;
  localparam logic [IDX_W-1:0] IDX_WAVEFORM = 5'h03;
  localparam logic [IDX_W-1:0] IDX_RESTORE = 5'h11;
  localparam logic [IDX_W-1:0] IDX_MODE = 5'h02;
  localparam logic [IDX_W-1:0] IDX_ORIGIN = 5'h14;

  // Value encodings of the integer parameters.
  localparam logic [3:0] RANGE_LOW = 4'h0;
  localparam logic [3:0] RANGE_HIGH = 4'h1;
  localparam logic [3:0] MODE_CURRENT = 4'h1;
  localparam logic [3:0] MODE_SHUNT_REGULATOR = 4'h6;
  localparam logic [3:0] WAVE_SINE = 4'h0;
  localparam logic [3:0] WAVE_RAMP = 4'h3;
  localparam logic [3:0] RESTORE_SOFT = 4'h1;
  localparam logic [3:0] RESTORE_HARD = 4'h2;
  localparam logic [3:0] BOOL_OFF = 4'h0;
  localparam logic [3:0] BOOL_ON = 4'h1;
  localparam logic [3:0] ORIGIN_LOCAL = 4'h0;
  localparam logic [3:0] ORIGIN_FUNCGEN = 4'h1;
  localparam logic [3:0] ORIGIN_ANALOG = 4'h2;

  // Device write addresses, entry 0 on the right.
  localparam logic [NUM_PARAMS-1:0][15:0] PARAM_WR_ADDR = {
    16'h80a0, 16'h8060, 16'h8030, 16'h8010, 16'h71b0, 16'h7190, 16'h7170,
    16'h7150, 16'h7130, 16'h7110, 16'h70f0, 16'h70d0, 16'h70b0, 16'h7090,
    16'h7070, 16'h7050, 16'h7030, 16'h7010, 16'h6030, 16'h6010, 16'h50f0};
  // Device query addresses; the restore entry has none and holds zero.
  localparam logic [NUM_PARAMS-1:0][15:0] PARAM_RD_ADDR = {
    16'h80b0, 16'h8070, 16'h8020, 16'h0000, 16'h71c0, 16'h71a0, 16'h7180,
    16'h7160, 16'h7140, 16'h7120, 16'h7100, 16'h70e0, 16'h70c0, 16'h70a0,
    16'h7080, 16'h7060, 16'h7040, 16'h7020, 16'h6040, 16'h6020, 16'h5100};
  localparam logic [NUM_PARAMS-1:0] PARAM_FLOAT = 21'h01fff1;
  localparam logic [NUM_PARAMS-1:0] PARAM_READABLE = 21'h1dffff;
  // Legal integer value limits; float entries are not range checked.
  localparam logic [NUM_PARAMS-1:0][3:0] PARAM_MIN = {
    ORIGIN_LOCAL, BOOL_OFF, BOOL_OFF, RESTORE_SOFT, 52'h0, WAVE_SINE,
    MODE_CURRENT, RANGE_LOW, 4'h0};
  localparam logic [NUM_PARAMS-1:0][3:0] PARAM_MAX = {
    ORIGIN_ANALOG, BOOL_ON, BOOL_ON, RESTORE_HARD, 52'h0, WAVE_RAMP,
    MODE_SHUNT_REGULATOR, RANGE_HIGH, 4'h0};

  // Software register map of the controller.
  localparam int unsigned SW_ADDR_W = 8;
  localparam logic [SW_ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [SW_ADDR_W-1:0] REG_WDATA = 8'h04;
  localparam logic [SW_ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [SW_ADDR_W-1:0] REG_RDATA = 8'h0c;
  localparam logic [SW_ADDR_W-1:0] REG_SHADOW = 8'h10;
  localparam int unsigned CMD_READ_BIT = 8;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_TIMEOUT = 2;
  localparam int unsigned ST_REFUSED = 3;
  localparam int unsigned ST_GEN_ACTIVE = 4;
  localparam logic [31:0] WDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    LCF_IDLE = 2'b00,
    LCF_SEND = 2'b01,
    LCF_WAIT = 2'b11
  } lcf_state_e;

  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [1:0] count;
    logic [31:0] data;
  } lcf_req_s;

  typedef struct packed {
    logic [15:0] word;
    logic last;
  } lcf_word_s;

endpackage

// ### verif/lcf_dev_model.sv
// Behavioural model of the electronic load's parameter registers on the frame link.
`timescale 1ns/1ns
`default_nettype none
module lcf_dev_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mute,
  input wire logic link_tx_valid,
  output logic link_tx_ready,
  input wire lcf_pkg::lcf_word_s link_tx,
  output logic link_rx_valid,
  output lcf_pkg::lcf_word_s link_rx
);
  import lcf_pkg::*;
  logic [15:0] frame[$];
  logic [15:0] resp[$];
  logic [31:0] mem[logic [15:0]];
  logic [31:0] last_func;
  logic [31:0] last_addr;
  logic [31:0] last_cnt;
  logic [31:0] v;
  logic [15:0] key;
  logic [15:0] w;
  logic phase;
  int frames;
  int gap;

  // Raw words of positive floats order like unsigned numbers; a set sign bit is below any limit.
  function automatic logic [31:0] clamp(input logic [31:0] f, input logic [31:0] lo,
                                        input logic [31:0] hi);
    if (f[31] || (f < lo)) begin
      return lo;
    end
    if (f > hi) begin
      return hi;
    end
    return f;
  endfunction

  // A slow device takes a word only every other cycle, so the host must hold it.
  assign link_tx_ready = !slow || phase;

  // Frame decode, storage and answer; a silent link shows inverted stale words.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame.delete();
      resp.delete();
      mem.delete();
      mem[16'h80a0] = 32'h0;
      frames = 0;
      gap = 0;
      phase <= 1'b0;
      link_rx_valid <= 1'b0;
      link_rx <= '0;
    end else begin
      phase <= !phase; // Host and model must see the same ready at each edge.
      if (link_tx_valid && link_tx_ready) begin
        frame.push_back(link_tx.word);
        if (link_tx.last) begin
          last_func = 32'(frame[0]);
          last_addr = 32'(frame[1]);
          last_cnt = 32'(frame[2]);
          frames++;
          if (frame[0] == 16'h0010) begin
            v = {frame[3], frame[4]};
            // Slew requests below the slowest rate of one unit per millisecond rise to it.
            if (frame[1] == 16'h50f0) begin
              v = clamp(v, 32'h3f80_0000, 32'h7fff_ffff);
            end
            // Durations are held between 2 ms and 65000 ms.
            if (frame[1] inside {16'h7070, 16'h70d0, 16'h70f0, 16'h7190, 16'h71b0}) begin
              v = clamp(v, 32'h4000_0000, 32'h477d_e800);
            end
            mem[frame[1]] = v;
          end else if (frame[0] == 16'h0006) begin
            mem[frame[1]] = {16'h0, frame[2]};
          end
          // Either restore kind brings the set-point source back to local.
          if (frame[0] == 16'h0006 && frame[1] == 16'h8010) begin
            mem[16'h80a0] = 32'h0;
          end
          key = (frame[1] == 16'h8020) ? 16'h8030 : frame[1] - 16'h10;
          v = mem.exists(key) ? mem[key] : 32'h0;
          if (frame[0] == 16'h0003 && frame[2] == 16'h2) begin
            resp.push_back(v[31:16]);
          end
          resp.push_back(frame[0] == 16'h0003 ? v[15:0] : frame[1]);
          if (mute) begin
            resp.delete();
          end
          frame.delete();
          gap = slow ? 3 : 0;
        end
      end
      if (gap > 0) begin
        gap--;
        link_rx_valid <= 1'b0;
        link_rx <= '{word: ~link_rx.word, last: 1'b0};
      end else if (resp.size() > 0) begin
        w = resp.pop_front();
        link_rx_valid <= 1'b1;
        link_rx <= '{word: w, last: resp.size() == 0};
      end else begin
        link_rx_valid <= 1'b0;
        link_rx <= '{word: ~link_rx.word, last: 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/load_control_funcgen_regs_test.sv
// Self-checking bench for the load controller host against the device model.
`timescale 1ns/1ns
`default_nettype none
module load_control_funcgen_regs_test;
  import lcf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic link_tx_valid;
  logic link_tx_ready;
  lcf_word_s link_tx;
  logic link_rx_valid;
  lcf_word_s link_rx;
  logic slow = 1'b0;
  logic mute = 1'b0;
  logic [31:0] st;
  logic [31:0] rd;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  lcf_host_ctrl #(.TIMEOUT_CYCLES(64)) dut (
    .clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link_tx_valid(link_tx_valid),
    .link_tx_ready(link_tx_ready), .link_tx(link_tx), .link_rx_valid(link_rx_valid),
    .link_rx(link_rx));

  lcf_dev_model dev (
    .clk(clk), .rst_n(rst_n), .slow(slow), .mute(mute), .link_tx_valid(link_tx_valid),
    .link_tx_ready(link_tx_ready), .link_tx(link_tx), .link_rx_valid(link_rx_valid),
    .link_rx(link_rx));

  // 100 MHz clock.
  always #5 clk = !clk;

  // A hang ends the run as a failure rather than stalling forever.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The extra edge keeps two strobes from being assigned in one time step.
  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
    @(posedge clk);
  endtask

  task automatic run(input logic [4:0] idx, input logic rdb, input logic [31:0] val);
    sw_write(REG_WDATA, val);
    sw_write(REG_CMD, {23'h0, rdb, 3'h0, idx});
    st = 32'h1;
    for (int n = 0; n < 100 && st[ST_BUSY] !== 1'b0; n++) begin
      sw_read(REG_STATUS, st);
    end
    sw_read(REG_RDATA, rd);
  endtask

  task automatic t_reset();
    sw_read(REG_STATUS, st);
    chk(st, 32'h0);
    sw_read(REG_SHADOW, st);
    chk(st, 32'h0);
    sw_read(8'h40, st);
    chk(st, 32'h0);
  endtask

  // Float write then read-back, with the device stalling and answering late.
  task automatic float_case(input int i);
    logic [15:0] wa;
    logic [31:0] v;
    wa = (i == 0) ? 16'h50f0 : 16'h7030 + 16'((i - 4) * 32);
    v = 32'h4120_00a5 ^ (32'(i) << 20);
    run(5'(i), 1'b0, v);
    chk(st & 32'hf, 32'h2);
    chk(dev.mem[wa], v);
    chk(dev.last_func, 32'h10);
    chk(dev.last_cnt, 32'h2);
    run(5'(i), 1'b1, 32'h0);
    chk(dev.last_addr, 32'(wa) + 32'h10);
    chk(dev.last_func, 32'h3);
    chk(rd, v);
  endtask

  task automatic int_case(input logic [4:0] idx, input logic [15:0] wa, input logic [15:0] ra,
                          input int val);
    run(idx, 1'b0, 32'(val));
    chk(st & 32'hf, 32'h2);
    chk(dev.mem[wa], 32'(val));
    chk(dev.last_func, 32'h6);
    run(idx, 1'b1, 32'h0);
    chk(dev.last_addr, 32'(ra));
    chk(rd, 32'(val));
  endtask

  task automatic t_ints();
    for (int v = 0; v <= 1; v++) int_case(5'd1, 16'h6010, 16'h6020, v);
    for (int v = 1; v <= 6; v++) int_case(5'd2, 16'h6030, 16'h6040, v);
    for (int v = 0; v <= 3; v++) int_case(5'd3, 16'h7010, 16'h7020, v);
    for (int v = 0; v <= 1; v++) int_case(5'd18, 16'h8030, 16'h8020, v);
    for (int v = 0; v <= 1; v++) int_case(5'd19, 16'h8060, 16'h8070, v);
    for (int v = 0; v <= 2; v++) int_case(5'd20, 16'h80a0, 16'h80b0, v);
  endtask

  // Generator flag follows the source; a restore returns the source to local.
  task automatic t_gen();
    int_case(5'd20, 16'h80a0, 16'h80b0, 1);
    chk({31'h0, st[ST_GEN_ACTIVE]}, 32'h1);
    sw_read(REG_CMD, st);
    chk(st, 32'h0000_0114);
    sw_read(REG_SHADOW, st);
    chk(st & 32'hff, 32'h31);
    for (int v = 1; v <= 2; v++) begin
      run(5'd17, 1'b0, 32'(v));
      chk(dev.last_addr, 32'h8010);
      chk(dev.mem[16'h8010], 32'(v));
      run(5'd20, 1'b1, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, st[ST_GEN_ACTIVE]}, 32'h0);
    end
  endtask

  // Illegal values, the query-less restore and a command while busy send no frame.
  task automatic t_refuse();
    int n;
    n = dev.frames;
    run(5'd2, 1'b0, 32'h0);
    chk({31'h0, st[ST_REFUSED]}, 32'h1);
    run(5'd2, 1'b0, 32'h7);
    chk({31'h0, st[ST_REFUSED]}, 32'h1);
    run(5'd20, 1'b0, 32'h3);
    chk({31'h0, st[ST_REFUSED]}, 32'h1);
    run(5'd1, 1'b0, 32'h2);
    chk({31'h0, st[ST_REFUSED]}, 32'h1);
    run(5'd3, 1'b0, 32'h4);
    chk({31'h0, st[ST_REFUSED]}, 32'h1);
    run(5'd17, 1'b1, 32'h0);
    chk({31'h0, st[ST_REFUSED]}, 32'h1);
    run(5'd21, 1'b0, 32'h0);
    chk(32'(dev.frames), 32'(n));
    sw_write(REG_WDATA, 32'h1);
    sw_write(REG_CMD, 32'h1);
    run(5'd2, 1'b0, 32'h1);
    chk(st & 32'hf, 32'ha);
    chk(32'(dev.frames), 32'(n + 1));
    sw_read(REG_WDATA, st);
    chk(st, 32'h1);
  endtask

  task automatic t_timeout();
    mute <= 1'b1;
    run(5'd0, 1'b1, 32'h0);
    chk(st & 32'hf, 32'h4);
    mute <= 1'b0;
    run(5'd0, 1'b1, 32'h0);
    chk(st & 32'hf, 32'h2);
  endtask

  // Floats leave unchecked; the device clamps slew and durations to their limits.
  task automatic t_clamp();
    run(5'd0, 1'b0, 32'h3f00_0000);
    run(5'd0, 1'b1, 32'h0);
    chk(rd, 32'h3f80_0000);
    run(5'd6, 1'b0, 32'h3f80_0000);
    run(5'd6, 1'b1, 32'h0);
    chk(rd, 32'h4000_0000);
    run(5'd16, 1'b0, 32'h4780_0000);
    run(5'd16, 1'b1, 32'h0);
    chk(rd, 32'h477d_e800);
  endtask

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    slow <= 1'b1;
    for (int i = 0; i <= 16; i++) begin
      if (i == 0 || i >= 4) float_case(i);
    end
    slow <= 1'b0;
    t_ints();
    t_gen();
    t_refuse();
    t_timeout();
    t_clamp();
    finish_test();
  end
endmodule
`default_nettype wire
